// ### motion_block.sv
`timescale 1ns/1ps
`include "motion_block_regs.svh"
// Notes on behaviour
// [RULE1] Fully automatic: motion starts detection unaided.
// [RULE2] Semi I: motion ignored until manual ON.
// [RULE3] Semi I: manual ON starts detection and delay.
// [RULE4] Semi I: end needs new manual ON.
// [RULE5] Semi II: auto start, no delay timer.
// [RULE6] Semi II: only manual OFF ends detection.
// [RULE7] Semi II refused with light control; a refused write keeps the old mode but sets light, even if it is Semi II.
// [RULE8] No reaction: basic state, no telegrams.
// [RULE9] No reaction clears light-control presence.
// [RULE10] Disabling recovery: disable, resume basic.
// [RULE11] Disabling recovery tells light control.
// [RULE12] Detection recovery: start, send, run delay.
// [RULE13] Brightness bypass only when below twilight.
// [RULE14] Delay expiry ends recovered detection.
// [RULE15] Detection recovery asserts light-control presence.
// [RULE16] Restore reloads state saved before failure.
// [RULE17] Skip when inactive; download beats supply.
// [RULE18] Two outputs, format per function.
// [RULE19] Output with no function stays silent.
// [RULE20] Switching sends one-bit ON/OFF.
// [RULE21] Staircase repeats ON cyclically.
// [RULE22] Forced position sends two-bit value.
// [RULE23] Dimming sends percent 0 to 100.
// [RULE24] Motion retriggers the delay timer.
module motion_block (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Sensor and bus events, one-cycle pulses except below_twilight.
  input  wire logic        motion,
  input  wire logic        below_twilight,
  input  wire logic        manual_on,
  input  wire logic        manual_off,
  input  wire logic        disable_begin,
  input  wire logic        disable_end,
  input  wire logic        supply_return,
  input  wire logic        download_done,
  // Output objects 1 and 2 of the first function block.
  output logic             out1_valid,
  output logic [7:0]       out1_data,
  output logic             out2_valid,
  output logic [7:0]       out2_data,
  // Indications to the light-control function.
  output logic             presence_lc,
  output logic             disable_lc
);

  // Bus slave state.
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_bvalid, next_arready, next_rvalid, next_awready, next_wready;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        do_write;

  // Configuration registers.
  logic [31:0] ctrl, next_ctrl, outcfg, next_outcfg;
  logic [23:0] delay_len, next_delay_len, repeat_len, next_repeat_len;
  logic        mode_err, next_mode_err;

  // Function block state.
  motion_block_pkg::state_type st, next_st, resume, next_resume, saved, next_saved;
  logic [23:0] timer, next_timer, stair, next_stair;
  logic        bypass, next_bypass;
  logic        next_presence_lc, next_disable_lc;
  logic        send, send_on, send_rep;
  logic        next_out1_valid, next_out2_valid;
  logic [7:0]  next_out1_data, next_out2_data;

  // Decoded configuration.
  motion_block_pkg::mode_type     mode;
  motion_block_pkg::out_func_type f1, f2;
  motion_block_pkg::recovery_type rec;
  logic light, bdep, rec_event, qualified;

  assign mode = motion_block_pkg::mode_type'(ctrl[`CTRL_MODE]);
  assign f1 = motion_block_pkg::out_func_type'(outcfg[`OUT_F1]);
  assign f2 = motion_block_pkg::out_func_type'(outcfg[`OUT_F2]);
  assign light = ctrl[`CTRL_LIGHT];
  assign bdep = ctrl[`CTRL_BDEP];
  // Inactive blocks skip recovery; a download overrides a supply return.
  assign rec_event = ctrl[`CTRL_ACTIVE] & (supply_return | download_done); // [RULE17]
  assign rec = motion_block_pkg::recovery_type'(download_done ?
               ctrl[`CTRL_DLREC] : ctrl[`CTRL_SRREC]); // [RULE17]
  // Motion counts when brightness does not matter or the room is dark enough.
  assign qualified = motion & (~bdep | below_twilight | bypass);
  assign do_write = aw_held & w_held & ~bvalid;

  // ON or OFF value of one output object in its function's format.
  function automatic logic [7:0] encode(input motion_block_pkg::out_func_type f,
                                        input logic on, input logic [6:0] dim);
    logic [6:0] pct;
    pct = (dim > `DIM_MAX) ? `DIM_MAX : dim;
    case (f)
      motion_block_pkg::OUT_SWITCH: encode = {7'h00, on}; // [RULE20]
      motion_block_pkg::OUT_STAIR:  encode = {7'h00, on}; // [RULE21]
      motion_block_pkg::OUT_FORCED: encode = {6'h00, 1'b1, on}; // [RULE22]
      motion_block_pkg::OUT_DIM:    encode = on ? {1'b0, pct} : 8'h00; // [RULE23]
      default:                      encode = 8'h00;
    endcase
  endfunction : encode

  // Write and read channels; address and data are taken in either order.
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = ~rvalid & ~arready;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      case (aw_addr)
        `OFS_CTRL, `OFS_OUTCFG, `OFS_DELAY, `OFS_REPEAT, `OFS_SAVED: next_bresp = 2'h0;
        default: next_bresp = 2'h2;
      endcase
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = 2'h0;
      case (araddr)
        `OFS_CTRL:   next_rdata = ctrl;
        `OFS_OUTCFG: next_rdata = outcfg;
        `OFS_DELAY:  next_rdata = {8'h00, delay_len};
        `OFS_REPEAT: next_rdata = {8'h00, repeat_len};
        `OFS_STATUS: next_rdata = {26'h0, mode_err, bypass, disable_lc, presence_lc, st};
        `OFS_SAVED:  next_rdata = {30'h0, saved};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = 2'h2;
        end
      endcase
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready = ~next_w_held & ~next_bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_held, w_held, awready, wready, aw_addr, w_data, w_strb, bvalid, bresp, arready,
       rvalid, rresp, rdata} <= '0;
    end else begin
      {aw_held, w_held, awready, wready, aw_addr, w_data, w_strb, bvalid, bresp, arready,
       rvalid, rresp, rdata} <= {next_aw_held, next_w_held, next_awready, next_wready,
       next_aw_addr, next_w_data, next_w_strb, next_bvalid, next_bresp, next_arready,
       next_rvalid, next_rresp, next_rdata};
    end
  end

  // Configuration writes; byte enables are honoured lane by lane for the control word only.
  always_comb begin
    logic [31:0] merged;
    merged = ctrl;
    next_ctrl = ctrl;
    next_outcfg = outcfg;
    next_delay_len = delay_len;
    next_repeat_len = repeat_len;
    next_mode_err = mode_err;
    for (int i = 0; i < 4; i++) begin
      merged[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : ctrl[i*8 +: 8];
    end
    if (do_write) begin
      case (aw_addr)
        `OFS_CTRL: begin
          // The light-control coupling cannot run with manual-off operation; a refused write keeps the old mode, Semi II included, but takes light.
          if (merged[`CTRL_LIGHT] &&
              merged[`CTRL_MODE] == 2'(motion_block_pkg::MODE_SEMI2)) begin
            next_ctrl = {merged[31:2], ctrl[`CTRL_MODE]}; // [RULE7]
            next_mode_err = 1'b1; // [RULE7]
          end else begin
            next_ctrl = merged;
            next_mode_err = 1'b0;
          end
        end
        `OFS_OUTCFG: next_outcfg = w_data;
        `OFS_DELAY:  next_delay_len = w_data[23:0];
        `OFS_REPEAT: next_repeat_len = w_data[23:0];
        default:     next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ctrl, outcfg, delay_len, repeat_len, mode_err} <=
        {`CTRL_RST, `OUTCFG_RST, `DELAY_RST, `REPEAT_RST, 1'b0};
    end else begin
      {ctrl, outcfg, delay_len, repeat_len, mode_err} <=
        {next_ctrl, next_outcfg, next_delay_len, next_repeat_len, next_mode_err};
    end
  end

  // Detection sequence, recovery and telegram requests.
  always_comb begin
    next_st = st;
    next_resume = resume;
    next_timer = timer;
    next_stair = stair;
    next_bypass = bypass;
    next_presence_lc = presence_lc;
    next_disable_lc = disable_lc;
    send = 1'b0;
    send_on = 1'b0;
    send_rep = 1'b0;
    if (rec_event) begin
      case (rec)
        motion_block_pkg::REC_DISABLE: begin
          next_st = motion_block_pkg::ST_DISABLED;
          next_resume = motion_block_pkg::ST_BASIC; // [RULE10]
          next_timer = 24'h0;
          next_presence_lc = 1'b0;
          next_disable_lc = light; // [RULE11]
          send = ctrl[`CTRL_DISTX]; // [RULE10]
        end
        motion_block_pkg::REC_DETECT: begin
          next_st = motion_block_pkg::ST_DETECT; // [RULE12]
          next_timer = delay_len; // [RULE12]
          next_stair = repeat_len;
          next_bypass = bdep & below_twilight; // [RULE13]
          next_presence_lc = light; // [RULE15]
          next_disable_lc = 1'b0;
          send = 1'b1; // [RULE12]
          send_on = 1'b1;
        end
        motion_block_pkg::REC_RESTORE: begin
          // Only a supply return has a saved state; a download falls back to basic.
          next_st = download_done ? motion_block_pkg::ST_BASIC : saved; // [RULE16]
          next_timer = (!download_done && saved == motion_block_pkg::ST_DETECT) ?
                       delay_len : 24'h0;
          next_presence_lc = light & ~download_done &
                             (saved == motion_block_pkg::ST_DETECT);
          next_disable_lc = light & ~download_done &
                            (saved == motion_block_pkg::ST_DISABLED);
          next_resume = motion_block_pkg::ST_BASIC;
          next_bypass = 1'b0;
        end
        default: begin
          next_st = motion_block_pkg::ST_BASIC; // [RULE8]
          next_timer = 24'h0; // [RULE8]
          next_bypass = 1'b0;
          next_presence_lc = 1'b0; // [RULE9]
          next_disable_lc = 1'b0;
        end
      endcase
    end else begin
      case (st)
        motion_block_pkg::ST_BASIC: begin
          if (disable_begin) begin
            next_st = motion_block_pkg::ST_DISABLED;
            next_resume = motion_block_pkg::ST_BASIC;
            next_disable_lc = light;
            send = ctrl[`CTRL_DISTX];
          end else if ((mode == motion_block_pkg::MODE_SEMI1) ? manual_on : // [RULE2]
                       qualified) begin // [RULE1]
            next_st = motion_block_pkg::ST_DETECT; // [RULE3]
            // Manual-off operation runs without any delay timer.
            next_timer = (mode == motion_block_pkg::MODE_SEMI2) ? 24'h0 : delay_len; // [RULE5]
            next_stair = repeat_len;
            next_presence_lc = light;
            send = 1'b1;
            send_on = 1'b1;
          end
        end
        motion_block_pkg::ST_DETECT: begin
          next_stair = (stair == 24'h0) ? repeat_len : stair - 24'h1;
          send_rep = (stair == 24'h0); // [RULE21]
          if (timer != 24'h0) begin
            next_timer = timer - 24'h1;
          end
          if (disable_begin) begin
            next_st = motion_block_pkg::ST_DISABLED;
            next_resume = motion_block_pkg::ST_DETECT;
            next_timer = 24'h0;
            next_presence_lc = 1'b0;
            next_disable_lc = light;
            send = ctrl[`CTRL_DISTX];
            send_rep = 1'b0;
          end else if ((mode != motion_block_pkg::MODE_AUTO && manual_off) || // [RULE6]
                       (mode != motion_block_pkg::MODE_SEMI2 &&
                        timer == 24'h1 && !qualified)) begin // [RULE14]
            // Back to basic; semi I then waits for a fresh manual ON.
            next_st = motion_block_pkg::ST_BASIC; // [RULE4]
            next_timer = 24'h0;
            next_bypass = 1'b0;
            next_presence_lc = 1'b0;
            send = 1'b1;
            send_rep = 1'b0;
          end else if (qualified && mode != motion_block_pkg::MODE_SEMI2) begin
            next_timer = delay_len; // [RULE24]
          end
        end
        motion_block_pkg::ST_DISABLED: begin
          if (disable_end) begin
            next_st = resume;
            next_timer = (resume == motion_block_pkg::ST_DETECT &&
                          mode != motion_block_pkg::MODE_SEMI2) ? delay_len : 24'h0;
            next_stair = repeat_len;
            next_disable_lc = 1'b0;
            next_presence_lc = light & (resume == motion_block_pkg::ST_DETECT);
          end
        end
        default: next_st = motion_block_pkg::ST_BASIC;
      endcase
    end
    // The saved copy tracks the live state so that a restore finds it.
    next_saved = next_st;
  end

  // Telegram outputs; a function of none never raises its valid.
  always_comb begin
    next_out1_valid = (send | (send_rep & f1 == motion_block_pkg::OUT_STAIR)) &
                      (f1 != motion_block_pkg::OUT_NONE); // [RULE19]
    next_out2_valid = (send | (send_rep & f2 == motion_block_pkg::OUT_STAIR)) &
                      (f2 != motion_block_pkg::OUT_NONE); // [RULE19]
    next_out1_data = encode(f1, send_on | send_rep, outcfg[`OUT_DIM]); // [RULE18]
    next_out2_data = encode(f2, send_on | send_rep, outcfg[`OUT_DIM]); // [RULE18]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= motion_block_pkg::ST_BASIC;
      resume <= motion_block_pkg::ST_BASIC;
      saved <= motion_block_pkg::ST_BASIC;
      {timer, stair, bypass, presence_lc, disable_lc, out1_valid, out1_data, out2_valid,
       out2_data} <= '0;
    end else begin
      st <= next_st;
      resume <= next_resume;
      // A write to the saved word stands in for the non-volatile copy.
      saved <= (do_write && aw_addr == `OFS_SAVED) ?
               motion_block_pkg::state_type'(w_data[1:0]) : next_saved;
      {timer, stair, bypass, presence_lc, disable_lc, out1_valid, out1_data, out2_valid,
       out2_data} <= {next_timer, next_stair, next_bypass, next_presence_lc, next_disable_lc,
       next_out1_valid, next_out1_data, next_out2_valid, next_out2_data};
    end
  end

endmodule : motion_block

// ### motion_block_regs.svh
`ifndef MOTION_BLOCK_REGS_SVH
`define MOTION_BLOCK_REGS_SVH
// Register byte offsets.
`define OFS_CTRL    8'h00
`define OFS_OUTCFG  8'h04
`define OFS_DELAY   8'h08
`define OFS_REPEAT  8'h0C
`define OFS_STATUS  8'h10
`define OFS_SAVED   8'h14
// Control register fields.
`define CTRL_MODE   1:0
`define CTRL_SRREC  3:2
`define CTRL_DLREC  5:4
`define CTRL_LIGHT  6
`define CTRL_BDEP   7
`define CTRL_ACTIVE 8
`define CTRL_DISTX  9
// Output configuration fields.
`define OUT_F1      2:0
`define OUT_F2      6:4
`define OUT_DIM     14:8
// Reset values.
`define CTRL_RST    32'h0000_0100
`define OUTCFG_RST  32'h0000_6401
`define DELAY_RST   24'h0F_4240
`define REPEAT_RST  24'h4C_4B40
// Highest dimming value, in percent.
`define DIM_MAX     7'h64
`endif

// ### motion_block_pkg.sv
package motion_block_pkg;
  typedef enum logic [1:0] {MODE_AUTO, MODE_SEMI1, MODE_SEMI2, MODE_RSVD} mode_type;
  typedef enum logic [1:0] {REC_NONE, REC_DISABLE, REC_DETECT, REC_RESTORE} recovery_type;
  typedef enum logic [2:0] {
    OUT_NONE, OUT_SWITCH, OUT_STAIR, OUT_FORCED, OUT_DIM
  } out_func_type;
  typedef enum logic [1:0] {ST_BASIC, ST_DETECT, ST_DISABLED} state_type;
endpackage : motion_block_pkg

// ### motion_block_sva.sv
`timescale 1ns/1ps
`include "motion_block_regs.svh"
module motion_block_sva (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus handshakes.
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  // Recovery events.
  input wire logic        supply_return,
  input wire logic        download_done,
  // Telegrams and light-control indications.
  input wire logic        out1_valid,
  input wire logic [7:0]  out1_data,
  input wire logic        out2_valid,
  input wire logic [7:0]  out2_data,
  input wire logic        presence_lc,
  input wire logic        disable_lc
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] ctrl_sh, ocfg_sh, next_ctrl_sh, next_ocfg_sh;
  logic        rec_ok, wr_go;

  // Shadow copies of the settings, taken with each whole-word write.
  always_comb begin
    next_ctrl_sh = ctrl_sh;
    next_ocfg_sh = ocfg_sh;
    if (wr_go && awaddr == `OFS_CTRL) next_ctrl_sh = wdata;
    if (wr_go && awaddr == `OFS_OUTCFG) next_ocfg_sh = wdata;
  end

  // The shadow leads the block by a cycle; settings change only while idle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_sh <= `CTRL_RST;
      ocfg_sh <= `OUTCFG_RST;
    end else begin
      ctrl_sh <= next_ctrl_sh;
      ocfg_sh <= next_ocfg_sh;
    end
  end

  // A supply return that the block must act on.
  assign rec_ok = supply_return && !download_done && ctrl_sh[8];
  assign wr_go = awvalid && awready && wvalid && wready;

  sequence s_wr_taken;
    wr_go;
  endsequence
  sequence s_wr_answer;
    ##[1:3] bvalid;
  endsequence
  property p_write_answer;
    s_wr_taken |-> s_wr_answer;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer missing");
  property p_read_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer missing");
  property p_switch_fmt;
    out1_valid && (ocfg_sh[2:0] == motion_block_pkg::OUT_SWITCH ||
      ocfg_sh[2:0] == motion_block_pkg::OUT_STAIR) |-> out1_data[7:1] == 7'h00;
  endproperty
  a_switch_fmt: assert property (p_switch_fmt) else $error("switch value not one bit");
  property p_forced_fmt;
    out2_valid && ocfg_sh[6:4] == motion_block_pkg::OUT_FORCED |-> out2_data[7:1] == 7'h01;
  endproperty
  a_forced_fmt: assert property (p_forced_fmt) else $error("forced value badly coded");
  property p_dim_value;
    out1_valid && ocfg_sh[2:0] == motion_block_pkg::OUT_DIM |-> out1_data == 8'h00 ||
      out1_data == (ocfg_sh[14:8] > 7'h64 ? 8'h64 : {1'b0, ocfg_sh[14:8]});
  endproperty
  a_dim_value: assert property (p_dim_value) else $error("dimming value wrong");
  property p_no_out2;
    ocfg_sh[6:4] == motion_block_pkg::OUT_NONE |-> !out2_valid;
  endproperty
  a_no_out2: assert property (p_no_out2) else $error("telegram on unused output");
  property p_rec_none;
    rec_ok && ctrl_sh[3:2] == 2'h0 |=> !out1_valid && !out2_valid && !presence_lc && !disable_lc;
  endproperty
  a_rec_none: assert property (p_rec_none) else $error("no-reaction recovery acted");
  property p_rec_disable;
    rec_ok && ctrl_sh[6] && ctrl_sh[3:2] == 2'h1 |=> disable_lc;
  endproperty
  a_rec_disable: assert property (p_rec_disable) else $error("disabling not passed");
  property p_rec_detect;
    rec_ok && !ctrl_sh[6] && ctrl_sh[3:2] == 2'h2 && ocfg_sh[2:0] != 3'h0
      |=> out1_valid && out1_data != 8'h00;
  endproperty
  a_rec_detect: assert property (p_rec_detect) else $error("detection start not sent");
  property p_rec_presence;
    rec_ok && ctrl_sh[6] && ctrl_sh[3:2] == 2'h2 |=> presence_lc;
  endproperty
  a_rec_presence: assert property (p_rec_presence) else $error("presence not raised");
  property p_inactive;
    (supply_return || download_done) && !ctrl_sh[8] |=> !out1_valid && !out2_valid;
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive block sent telegram");
endmodule : motion_block_sva

bind motion_block motion_block_sva chk_u (
  .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .bvalid,
  .arvalid, .arready, .rvalid, .supply_return, .download_done, .out1_valid, .out1_data,
  .out2_valid, .out2_data, .presence_lc, .disable_lc
);

// ### bus_actuator.sv
`timescale 1ns/1ps
module bus_actuator (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Telegram on one output object.
  input  wire logic       tel_valid,
  input  wire logic [7:0] tel_data,
  // Telegrams received and the last value.
  output int              count,
  output logic [7:0]      last
);
  // A telegram stands one cycle, so it is taken at that edge or lost.
  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= 0;
      last  <= 8'h00;
    end else if (tel_valid) begin
      count <= count + 1;
      last  <= tel_data;
    end
  end
endmodule : bus_actuator

// ### motion_block_test.sv
`timescale 1ns/1ps
`include "motion_block_regs.svh"
module motion_block_test;
  localparam int LIMIT = 6000;
  // One bit per event input.
  localparam logic [6:0] MOT = 7'h01, MON = 7'h02, MOFF = 7'h04, DB = 7'h08;
  localparam logic [6:0] DE = 7'h10, SUP = 7'h20, DL = 7'h40;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, below_twilight;
  logic        awready, wready, bvalid, arready, rvalid, out1_valid, out2_valid;
  logic        presence_lc, disable_lc;
  logic [7:0]  awaddr, araddr, out1_data, out2_data, l1, l2;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [6:0]  ev;
  logic [1:0]  bresp, rresp, resp;
  int          c1, c2, n1, n2, checked, miscompares, cycles;
  logic [31:0] rmask [3] = '{32'h0000_000F, 32'h0000_000B, 32'h0000_0007};
  logic [31:0] rexp [3] = '{32'h0000_0000, 32'h0000_000A, 32'h0000_0005};

  motion_block dut_u (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .motion(ev[0]), .below_twilight, .manual_on(ev[1]), .manual_off(ev[2]),
    .disable_begin(ev[3]), .disable_end(ev[4]), .supply_return(ev[5]),
    .download_done(ev[6]), .out1_valid, .out1_data, .out2_valid, .out2_data,
    .presence_lc, .disable_lc
  );
  bus_actuator act1_u (.aclk, .aresetn, .tel_valid(out1_valid), .tel_data(out1_data),
    .count(c1), .last(l1));
  bus_actuator act2_u (.aclk, .aresetn, .tel_valid(out2_valid), .tel_data(out2_data),
    .count(c2), .last(l2));

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Ready is looked at mid-cycle; each beat drops after the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    {aw, w} = 2'h3;
    while (aw || w) begin
      @(negedge aclk);
      {aw, w} = {aw & ~awready, w & ~wready};
      @(posedge aclk);
      {awvalid, wvalid} <= {aw, w};
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(v & m, e);
  endtask : rc

  // One-cycle event, then time for the telegram to land.
  task automatic pulse(input logic [6:0] e);
    @(posedge aclk);
    ev <= e;
    @(posedge aclk);
    ev <= 7'h00;
    repeat (2) @(posedge aclk);
  endtask : pulse

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // A hung block still reaches a verdict.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, below_twilight} = '0;
    {awaddr, araddr, wdata, ev, cycles, checked, miscompares} = '0;
    wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, then refused places.
    rc(`OFS_CTRL, 32'hFFFF_FFFF, `CTRL_RST);
    rc(`OFS_OUTCFG, 32'hFFFF_FFFF, `OUTCFG_RST);
    rc(`OFS_DELAY, 32'hFFFF_FFFF, {8'h00, `DELAY_RST});
    rc(`OFS_REPEAT, 32'hFFFF_FFFF, {8'h00, `REPEAT_RST});
    rd(8'h18);
    chk(resp, 2'h2);
    wr(`OFS_STATUS, 32'h0000_0003);
    chk(resp, 2'h2);
    $display("test registers finished");
    // Automatic start, both outputs, retriggered delay.
    wr(`OFS_OUTCFG, 32'h0000_6431);
    wr(`OFS_DELAY, 32'h0000_0014);
    pulse(MOT);
    chk(l1, 8'h01);
    chk(l2, 8'h03);
    rc(`OFS_STATUS, 32'h3, 32'h1);
    pulse(MOT);
    repeat (12) @(posedge aclk);
    chk(l1, 8'h01);
    repeat (20) @(posedge aclk);
    chk(l1, 8'h00);
    chk(l2, 8'h02);
    $display("test automatic finished");
    // Manual start mode.
    wr(`OFS_CTRL, 32'h0000_0101);
    n1 = c1;
    pulse(MOT);
    chk(c1 - n1, 0);
    pulse(MON);
    chk(l1, 8'h01);
    repeat (30) @(posedge aclk);
    chk(l1, 8'h00);
    n1 = c1;
    pulse(MOT);
    chk(c1 - n1, 0);
    pulse(MON);
    pulse(MOFF);
    chk(l1, 8'h00);
    chk(c1 - n1, 2);
    wr(`OFS_CTRL, 32'h0000_0142);
    rc(`OFS_STATUS, 32'h20, 32'h20);
    rc(`OFS_CTRL, 32'h3, 32'h1);
    $display("test manual on finished");
    // Manual end mode, then restore of the saved state.
    wr(`OFS_CTRL, 32'h0000_0102);
    pulse(MOT);
    repeat (40) @(posedge aclk);
    chk(l1, 8'h01);
    pulse(MOFF);
    chk(l1, 8'h00);
    pulse(MOT);
    chk(l1, 8'h01);
    wr(`OFS_CTRL, 32'h0000_010E);
    pulse(SUP);
    rc(`OFS_STATUS, 32'h3, 32'h1);
    pulse(MOFF);
    $display("test manual off finished");
    // Recovery from detection: none, disabling, detection, all with light control; then bypass, inactive block and download, without it.
    for (int r = 0; r < 3; r++) begin
      wr(`OFS_CTRL, 32'h0000_0140 | (r << 2));
      pulse(MOT);
      n1 = c1;
      pulse(SUP);
      rc(`OFS_STATUS, rmask[r], rexp[r]);
      chk(c1 - n1, r / 2);
      chk({disable_lc, presence_lc}, rexp[r][3:2]);
      repeat (40) @(posedge aclk);
      pulse(DE);
      rc(`OFS_STATUS, 32'h3, 32'h0);
    end
    wr(`OFS_CTRL, 32'h0000_0188);
    below_twilight <= 1'b1;
    pulse(SUP);
    rc(`OFS_STATUS, 32'h10, 32'h10);
    repeat (40) @(posedge aclk);
    below_twilight <= 1'b0;
    pulse(SUP);
    rc(`OFS_STATUS, 32'h10, 32'h0);
    repeat (40) @(posedge aclk);
    wr(`OFS_CTRL, 32'h0000_0008);
    n1 = c1;
    pulse(SUP);
    chk(c1 - n1, 0);
    wr(`OFS_CTRL, 32'h0000_0118);
    pulse(SUP | DL);
    rc(`OFS_STATUS, 32'h3, 32'h2);
    pulse(DE);
    pulse(DB);
    rc(`OFS_STATUS, 32'h3, 32'h2);
    pulse(DE);
    $display("test recovery finished");
    // Dimming values, an unused second output, and staircase repeats.
    wr(`OFS_CTRL, 32'h0000_0100);
    wr(`OFS_OUTCFG, 32'h0000_7F04);
    n2 = c2;
    pulse(MOT);
    chk(l1, 8'h64);
    repeat (30) @(posedge aclk);
    chk(l1, 8'h00);
    chk(c2 - n2, 0);
    wr(`OFS_OUTCFG, 32'h0000_3204);
    pulse(MOT);
    chk(l1, 8'h32);
    repeat (30) @(posedge aclk);
    wr(`OFS_REPEAT, 32'h0000_000A);
    wr(`OFS_DELAY, 32'h0000_00C8);
    wr(`OFS_OUTCFG, 32'h0000_6402);
    pulse(MOT);
    n1 = c1;
    repeat (60) @(posedge aclk);
    chk(c1 - n1 >= 4, 1'b1);
    chk(l1, 8'h01);
    $display("test outputs finished");
    give_verdict();
  end
endmodule : motion_block_test
